// >>> udfp_pkg.sv
// constants for the unknown-destination forwarding policy register bank
package udfp_pkg;
    localparam int          UDFP_ADDR_W        = 8;
    localparam int          UDFP_DATA_W        = 8;
    localparam int          UDFP_PORTS         = 5;
    localparam int          UDFP_MAC_W         = 48;

    localparam logic [7:0]  UDFP_OFS_UCAST     = 8'h83;
    localparam logic [7:0]  UDFP_OFS_MCAST     = 8'h84;
    localparam logic [7:0]  UDFP_OFS_VLAN      = 8'h85;
    localparam logic [7:0]  UDFP_OFS_IPMC      = 8'h86;

    localparam int          UDFP_MAP_LSB       = 0;
    localparam int          UDFP_MAP_MSB       = 4;
    localparam int          UDFP_EN_BIT        = 5;
    localparam int          UDFP_SELF_BIT      = 6;
    localparam int          UDFP_DRV_LSB       = 6;
    localparam int          UDFP_DRV_MSB       = 7;

    localparam logic [4:0]  UDFP_MAP_RESET     = 5'h00;
    localparam logic [1:0]  UDFP_DRV_RESET     = 2'h1;
    localparam logic [7:0]  UDFP_UCAST_RSVD    = 8'h80;
    localparam logic        UDFP_STRAP_IDLE    = 1'h1;

    // frame classes the forwarding engine can ask about
    typedef enum logic [1:0] {
        UDFP_CLS_UCAST = 2'b00,
        UDFP_CLS_MCAST = 2'b01,
        UDFP_CLS_VLAN  = 2'b10,
        UDFP_CLS_IPMC  = 2'b11
    } udfp_class_type;

    typedef enum logic [1:0] {
        UDFP_ST_SYNC_A = 2'b00,
        UDFP_ST_SYNC_B = 2'b01,
        UDFP_ST_LOAD   = 2'b10,
        UDFP_ST_DONE   = 2'b11
    } udfp_strap_type;
endpackage

// >>> udfp_bank.sv
// forwarding policy bank for unknown destinations, self filter and drive strength
//
// Function
// - 0x83 bit5 enables unknown unicast steering
// - unicast map bits4:0, zeros drop, ones flood
// - 0x84 bit5 enables non-IP unknown multicast steering
// - multicast map bits4:0, zeros drop, ones flood
// - 0x85 bit5 enables unknown VLAN steering
// - VLAN map bits4:0, bit0 is port1
// - 0x86 bit6 drops frames to own MAC
// - self drop at egress, own MAC compared
// - 0x86 bit5 enables unknown IP multicast steering
// - IP multicast map bits4:0, reset zero
// - 0x84 bits7:6 select drive 4/8/12/16 mA
// - drive field loaded from strap, upper inverted
`timescale 1ns/1ps
module udfp_bank
    import udfp_pkg::*;
(
    input  wire logic                           clk_in,
    input  wire logic                           rst_n_in,
    input  wire logic                           drive_strength_strap_pin_in,
    input  wire logic                           reg_wr_en_in,
    input  wire logic                           reg_rd_en_in,
    input  wire logic [udfp_pkg::UDFP_ADDR_W-1:0] reg_addr_in,
    input  wire logic [udfp_pkg::UDFP_DATA_W-1:0] reg_wr_data_in,
    output logic      [udfp_pkg::UDFP_DATA_W-1:0] reg_rd_data_out,
    output logic                                reg_rd_valid_out,
    input  wire logic                           lookup_valid_in,
    input  wire logic [1:0]                     lookup_class_in,
    input  wire logic [udfp_pkg::UDFP_PORTS-1:0] lookup_default_map_in,
    input  wire logic [udfp_pkg::UDFP_MAC_W-1:0] lookup_dest_mac_in,
    input  wire logic [udfp_pkg::UDFP_MAC_W-1:0] own_mac_in,
    output logic                                lookup_valid_out,
    output logic      [udfp_pkg::UDFP_PORTS-1:0] lookup_map_out,
    output logic                                self_drop_out,
    output logic      [1:0]                     drive_strength_out
);
    import udfp_pkg::*;

    localparam int NCLS = 4;

    // per-class enable and map; index is the class code
    logic [NCLS-1:0]       en_r,  en_nxt;
    logic [UDFP_PORTS-1:0] map_r [NCLS];
    logic [UDFP_PORTS-1:0] map_nxt [NCLS];
    logic                  self_en_r, self_en_nxt;
    logic [1:0]            drv_r, drv_nxt;
    logic [UDFP_DATA_W-1:0] rd_r, rd_nxt;
    logic                  rdv_r, rdv_nxt;
    logic                  strap_s1_r, strap_s2_r;
    udfp_strap_type        st_r, st_nxt;
    logic                  lv_r, lv_nxt;
    logic [UDFP_PORTS-1:0] lmap_r, lmap_nxt;
    logic                  ldrop_r, ldrop_nxt;
    logic [1:0]            wr_idx;
    logic                  wr_hit;

    // registers are 0x83..0x86, consecutive, so the offset from 0x83 picks the class
    always_comb begin
        wr_hit = (reg_addr_in >= UDFP_OFS_UCAST) && (reg_addr_in <= UDFP_OFS_IPMC);
        wr_idx = 2'(reg_addr_in - UDFP_OFS_UCAST);
    end

    // strap synchroniser: pin is asynchronous; idle level matches the pull-up
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_s1_r <= UDFP_STRAP_IDLE;
            strap_s2_r <= UDFP_STRAP_IDLE;
        end else begin
            strap_s1_r <= drive_strength_strap_pin_in;
            strap_s2_r <= strap_s1_r;
        end
    end

    // register writes, strap capture and read data
    always_comb begin
        en_nxt      = en_r;
        self_en_nxt = self_en_r;
        drv_nxt     = drv_r;
        st_nxt      = st_r;
        rd_nxt      = rd_r;
        rdv_nxt     = reg_rd_en_in;
        for (int i = 0; i < NCLS; i++) begin
            map_nxt[i] = map_r[i];
        end
        if (reg_wr_en_in && wr_hit) begin
            en_nxt[wr_idx]  = reg_wr_data_in[UDFP_EN_BIT];
            map_nxt[wr_idx] = reg_wr_data_in[UDFP_MAP_MSB:UDFP_MAP_LSB];
            if (reg_addr_in == UDFP_OFS_MCAST) begin
                drv_nxt = reg_wr_data_in[UDFP_DRV_MSB:UDFP_DRV_LSB];
            end
            if (reg_addr_in == UDFP_OFS_IPMC) begin
                self_en_nxt = reg_wr_data_in[UDFP_SELF_BIT];
            end
        end
        // strap is sampled once, after the synchroniser has filled
        case (st_r)
            UDFP_ST_SYNC_A: st_nxt = UDFP_ST_SYNC_B;
            UDFP_ST_SYNC_B: st_nxt = UDFP_ST_LOAD;
            UDFP_ST_LOAD: begin
                st_nxt  = UDFP_ST_DONE;
                drv_nxt = {~strap_s2_r, strap_s2_r};
            end
            UDFP_ST_DONE:   st_nxt = UDFP_ST_DONE;
            default:        st_nxt = UDFP_ST_SYNC_A;
        endcase
        if (reg_rd_en_in) begin
            rd_nxt = '0;
            if (wr_hit) begin
                rd_nxt[UDFP_MAP_MSB:UDFP_MAP_LSB] = map_r[wr_idx];
                rd_nxt[UDFP_EN_BIT]               = en_r[wr_idx];
            end
            case (reg_addr_in)
                UDFP_OFS_UCAST: rd_nxt = rd_nxt | UDFP_UCAST_RSVD;
                UDFP_OFS_MCAST: rd_nxt[UDFP_DRV_MSB:UDFP_DRV_LSB] = drv_r;
                UDFP_OFS_IPMC:  rd_nxt[UDFP_SELF_BIT] = self_en_r;
                default:        rd_nxt = rd_nxt;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_r      <= '0;
            self_en_r <= 1'b0;
            drv_r     <= UDFP_DRV_RESET;
            st_r      <= UDFP_ST_SYNC_A;
            rd_r      <= '0;
            rdv_r     <= 1'b0;
            for (int i = 0; i < NCLS; i++) begin
                map_r[i] <= UDFP_MAP_RESET;
            end
        end else begin
            en_r      <= en_nxt;
            self_en_r <= self_en_nxt;
            drv_r     <= drv_nxt;
            st_r      <= st_nxt;
            rd_r      <= rd_nxt;
            rdv_r     <= rdv_nxt;
            for (int i = 0; i < NCLS; i++) begin
                map_r[i] <= map_nxt[i];
            end
        end
    end

    // lookup: one-cycle answer to the forwarding engine
    always_comb begin
        lv_nxt    = lookup_valid_in;
        lmap_nxt  = lmap_r;
        ldrop_nxt = ldrop_r;
        if (lookup_valid_in) begin
            lmap_nxt  = en_r[lookup_class_in] ? map_r[lookup_class_in]
                                              : lookup_default_map_in;
            // drop at egress: mask every port rather than at ingress
            ldrop_nxt = self_en_r && (lookup_dest_mac_in == own_mac_in);
            if (ldrop_nxt) begin
                lmap_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lv_r    <= 1'b0;
            lmap_r  <= '0;
            ldrop_r <= 1'b0;
        end else begin
            lv_r    <= lv_nxt;
            lmap_r  <= lmap_nxt;
            ldrop_r <= ldrop_nxt;
        end
    end

    assign reg_rd_data_out    = rd_r;
    assign reg_rd_valid_out   = rdv_r;
    assign lookup_valid_out   = lv_r;
    assign lookup_map_out     = lmap_r;
    assign self_drop_out      = ldrop_r;
    assign drive_strength_out = drv_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_UCAST_EN_MAP: assert property (
        lookup_valid_in && lookup_class_in == UDFP_CLS_UCAST && en_r[0] && !self_en_r
        |=> lookup_map_out == $past(map_r[0]))
        else $error("unicast map not applied");
    AST_MAP_WRITE: assert property (
        reg_wr_en_in && reg_addr_in == UDFP_OFS_UCAST ##1 reg_rd_en_in
        && reg_addr_in == UDFP_OFS_UCAST && !reg_wr_en_in
        |=> reg_rd_data_out[4:0] == $past(reg_wr_data_in[4:0], 2))
        else $error("unicast map readback wrong");
    AST_MCAST_EN_MAP: assert property (
        lookup_valid_in && lookup_class_in == UDFP_CLS_MCAST && en_r[1] && !self_en_r
        |=> lookup_map_out == $past(map_r[1]))
        else $error("multicast map not applied");
    AST_VLAN_EN_MAP: assert property (
        lookup_valid_in && lookup_class_in == UDFP_CLS_VLAN && en_r[2] && !self_en_r
        |=> lookup_map_out == $past(map_r[2]))
        else $error("vlan map not applied");
    AST_IPMC_EN_MAP: assert property (
        lookup_valid_in && lookup_class_in == UDFP_CLS_IPMC && en_r[3] && !self_en_r
        |=> lookup_map_out == $past(map_r[3]))
        else $error("ip multicast map not applied");
    AST_SELF_DROP: assert property (
        lookup_valid_in && self_en_r && lookup_dest_mac_in == own_mac_in
        |=> self_drop_out && lookup_map_out == '0)
        else $error("self address frame not dropped");
    AST_SELF_PASS: assert property (
        lookup_valid_in && lookup_dest_mac_in != own_mac_in |=> !self_drop_out)
        else $error("frame dropped without address match");
    AST_DEFAULT_FWD: assert property (
        lookup_valid_in && !en_r[lookup_class_in] && !self_en_r
        |=> lookup_map_out == $past(lookup_default_map_in))
        else $error("default map not used with enable clear");
    AST_STRAP_LOAD: assert property (
        st_r == UDFP_ST_LOAD |=> drive_strength_out == {~$past(strap_s2_r), $past(strap_s2_r)})
        else $error("drive strength not loaded from strap");
    AST_DRV_WRITE: assert property (
        reg_wr_en_in && reg_addr_in == UDFP_OFS_MCAST && st_r != UDFP_ST_LOAD
        |=> drive_strength_out == $past(reg_wr_data_in[7:6]))
        else $error("drive strength write lost");
    AST_RD_VALID: assert property (
        reg_rd_en_in |=> reg_rd_valid_out && ($past(reg_addr_in) != UDFP_OFS_IPMC
        || reg_rd_data_out[UDFP_MAP_MSB:UDFP_MAP_LSB] == $past(map_r[3])))
        else $error("ip multicast map readback wrong");

    COV_SELF_DROP:   cover property (lookup_valid_in && self_en_r ##1 self_drop_out);
    COV_UCAST_FLOOD: cover property (lookup_valid_in && en_r[0] && map_r[0] == 5'h1f);
    COV_STRAP_LOW:   cover property (st_r == UDFP_ST_LOAD && !strap_s2_r);
    COV_DEFAULT:     cover property (lookup_valid_in && !en_r[lookup_class_in]);
endmodule

// >>> tb_top.sv
// self-checking bench for the unknown-destination forwarding policy bank
`timescale 1ns/1ps
module tb_top;
    import udfp_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        strap = 1'b1;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        lk_in = 1'b0;
    logic [1:0]  lk_cls = 2'h0;
    logic [4:0]  lk_def = 5'h00;
    logic [47:0] dest = 48'h0000_0000_0001;
    logic [47:0] own = 48'h0200_0000_00aa;
    logic        lk_out;
    logic [4:0]  lk_map;
    logic        drop;
    logic [1:0]  drv;
    int          failures = 0;
    int          compares = 0;
    always #5 clk_in = ~clk_in;
    udfp_bank u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .drive_strength_strap_pin_in(strap),
        .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr),
        .reg_wr_data_in(wdata), .reg_rd_data_out(rdata), .reg_rd_valid_out(rvalid),
        .lookup_valid_in(lk_in), .lookup_class_in(lk_cls), .lookup_default_map_in(lk_def),
        .lookup_dest_mac_in(dest), .own_mac_in(own), .lookup_valid_out(lk_out),
        .lookup_map_out(lk_map), .self_drop_out(drop), .drive_strength_out(drv));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr_en <= 1'b0;
        // let the register settle before anyone looks at it
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk_in);
        rd_en <= 1'b0;
        #1;
        chk("rd_valid", {7'h0, rvalid}, 8'h01);
        chk("rd_data", rdata, exp);
    endtask
    task automatic look(input logic [1:0] c, input logic [4:0] d, input logic [4:0] m,
                        input logic x);
        @(posedge clk_in);
        lk_in  <= 1'b1;
        lk_cls <= c;
        lk_def <= d;
        @(posedge clk_in);
        lk_in <= 1'b0;
        #1;
        chk("lk_valid", {7'h0, lk_out}, 8'h01);
        chk("lk_map", {3'h0, lk_map}, {3'h0, m});
        chk("self_drop", {7'h0, drop}, {7'h0, x});
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        strap    <= s;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        #1;
    endtask
    // address, write data, read-back value
    logic [7:0] rows [5][3] = '{'{8'h83, 8'hff, 8'hbf}, '{8'h84, 8'hff, 8'hff},
        '{8'h85, 8'hff, 8'h3f}, '{8'h86, 8'hff, 8'h7f}, '{8'h87, 8'hff, 8'h00}};
    // class, default map, expected map with 83=3f 84=c0 85=20 86=2a
    logic [4:0] lrows [4][3] = '{'{5'h0, 5'h03, 5'h1f}, '{5'h1, 5'h03, 5'h03},
        '{5'h2, 5'h1f, 5'h00}, '{5'h3, 5'h00, 5'h0a}};
    initial begin
        #100000;
        failures++;
        end_sim();
    end
    initial begin
        do_reset(1'b1);
        chk("drv_strap1", {6'h0, drv}, 8'h01);
        rd(8'h83, 8'h80);
        rd(8'h84, 8'h40);
        rd(8'h85, 8'h00);
        rd(8'h86, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], rows[i][2]);
        end
        chk("drv_16ma", {6'h0, drv}, 8'h03);
        wr(8'h83, 8'h3f);
        wr(8'h84, 8'hc0);
        wr(8'h85, 8'h20);
        wr(8'h86, 8'h2a);
        foreach (lrows[i])
            look(lrows[i][0][1:0], lrows[i][1], lrows[i][2], 1'b0);
        wr(8'h84, 8'h35);
        look(2'h1, 5'h03, 5'h15, 1'b0);
        chk("drv_4ma", {6'h0, drv}, 8'h00);
        // self filter off: own address passes
        dest <= own;
        look(2'h3, 5'h00, 5'h0a, 1'b0);
        wr(8'h86, 8'h6a);
        look(2'h3, 5'h00, 5'h00, 1'b1);
        look(2'h0, 5'h00, 5'h00, 1'b1);
        dest <= 48'h0200_0000_00ab;
        look(2'h3, 5'h00, 5'h0a, 1'b0);
        // write then read on the very next cycle
        @(posedge clk_in);
        wr_en <= 1'b1;
        addr  <= 8'h83;
        wdata <= 8'h25;
        @(posedge clk_in);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clk_in);
        rd_en <= 1'b0;
        #1;
        chk("b2b_rd_valid", {7'h0, rvalid}, 8'h01);
        chk("b2b_rd_data", rdata, 8'ha5);
        // second reset with the strap pulled low selects 12 mA
        do_reset(1'b0);
        chk("drv_strap0", {6'h0, drv}, 8'h02);
        rd(8'h84, 8'h80);
        rd(8'h86, 8'h00);
        end_sim();
    end
endmodule
